// file: bench/asc_line_model.sv
/*
  Remote serial transceiver on the line: decodes transmit frames and sends
  receive frames. Assumes the wire level is resolved by the bench.
*/
`timescale 1ns/100ps
`default_nettype none

module asc_line_model (
  input wire logic ref_clk,
  input wire logic tx_wire,
  input wire logic [15:0] tx_clks,
  input wire logic [15:0] rx_clks,
  input wire logic [7:0] send_seq,
  input wire logic [7:0] send_byte,
  output logic rx_line,
  output logic [7:0] got_byte,
  output logic got_stop,
  output logic [7:0] got_cnt
);
  // ****************************************
  // Frame decode and send
  // ****************************************
  logic [7:0] sh;
  logic [7:0] done;
  logic [9:0] fr;

  initial
  begin
    rx_line = 1'b1;
    got_byte = 8'h00;
    got_stop = 1'b0;
    got_cnt = 8'h00;
    done = 8'h00;
  end

  always
  begin
    @(posedge ref_clk);
    if (tx_wire === 1'b0)
    begin
      repeat (tx_clks / 2) @(posedge ref_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (tx_clks) @(posedge ref_clk);
        sh[i] = tx_wire;
      end
      repeat (tx_clks) @(posedge ref_clk);
      got_byte <= sh;
      got_stop <= tx_wire;
      got_cnt <= got_cnt + 8'h01;
    end
  end

  always
  begin
    @(posedge ref_clk);
    if (done !== send_seq)
    begin
      fr = {1'b1, send_byte, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        rx_line <= fr[i];
        repeat (rx_clks) @(posedge ref_clk);
      end
      done = done + 8'h01;
    end
  end
endmodule

`default_nettype wire

// file: bench/asc_serial_properties.sv
/*
  Checker for the asynchronous serial controller ports.
  Assumes it is bound to asc_serial and sees only its ports.
*/
`timescale 1ns/100ps
`default_nettype none

module asc_serial_properties (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic tx_line_oe,
  input wire logic serial_irq
);
  // ****************************************
  // Shadow of control writes
  // ****************************************
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  logic ever_r;
  logic ever_nxt;
  logic extw_r;
  logic extw_nxt;
  logic req;
  logic acc_w;
  logic acc_r;
  logic [2:0] idx;

  assign req = avs_read || avs_write;
  assign idx = avs_address[4:2];
  assign acc_w = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign acc_r = avs_read && !avs_waitrequest;

  always_comb
  begin
    ctl_nxt = ctl_r;
    if (acc_w && idx == asc_pkg::IDX_CTRL2)
    begin
      ctl_nxt = avs_writedata[7:0];
    end
    ever_nxt = ever_r | ctl_r[asc_pkg::CR2_TX_EN];
    extw_nxt = extw_r | (acc_w && (idx == asc_pkg::IDX_EXT_RX || idx == asc_pkg::IDX_EXT_TX));
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ctl_r <= 8'h00;
      ever_r <= 1'b0;
      extw_r <= 1'b0;
    end
    else
    begin
      ctl_r <= ctl_nxt;
      ever_r <= ever_nxt;
      extw_r <= extw_nxt;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("no wait state on new request");
  one_wait_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait state longer than one cycle");
  unmapped_zero_a: assert property (acc_r && idx == 3'h6 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  ctl_readback_a: assert property (acc_r && idx == asc_pkg::IDX_CTRL2
    |-> (avs_readdata[7:0] & 8'hFD) == (ctl_r & 8'hFD))
    else $error("control readback differs");
  irq_quiet_a: assert property (ctl_r[7:4] == 4'h0 && $past(ctl_r[7:4]) == 4'h0
    |-> !serial_irq)
    else $error("interrupt with all enables clear");
  pin_free_a: assert property (!ever_r |-> !tx_line_oe)
    else $error("transmit pin driven before enable");
  pin_driven_a: assert property (ctl_r[3] && $past(ctl_r[3]) && $past(ctl_r[3], 2)
    |-> tx_line_oe)
    else $error("transmit pin not driven while enabled");
  enable_wait_a: assert property ($rose(ctl_r[3]) && !ever_r |-> tx_line [*8])
    else $error("transmission started without idle bit");
  ext_reset_a: assert property (acc_r && !extw_r
    && (idx == asc_pkg::IDX_EXT_RX || idx == asc_pkg::IDX_EXT_TX) |-> avs_readdata == 32'h0)
    else $error("extended prescaler not zero after reset");

  tx_on_c: cover property ($rose(ctl_r[3]));
  irq_c: cover property ($rose(serial_irq));
  unmapped_c: cover property (acc_r && idx == 3'h6);
endmodule

`default_nettype wire

// file: bench/testbench.sv
/*
  Self-checking bench for asc_serial over Avalon-MM and the serial line.
  Assumes asc_pkg, asc_serial and the bench files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("Error %0t: got %h want %h", $time, a, b); end end

module testbench;
  logic ref_clk, sys_rst, avs_read, avs_write, rx_line, tx_line, tx_line_oe;
  logic avs_waitrequest, serial_irq, got_stop;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [15:0] tx_clks, rx_clks;
  logic [7:0] send_seq, send_byte, got_byte, got_cnt, q, s, c;
  int n_errors, num_checks;
  wire logic tx_wire = tx_line_oe ? tx_line : 1'b1;
  logic [2:0] z_idx [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [7:0] ie_v [4] = '{8'h80, 8'h40, 8'h30, 8'h00};
  logic ie_x [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  logic [7:0] bd [6] = '{8'h00, 8'h49, 8'h80, 8'hC0, 8'h08, 8'h00};
  logic [7:0] erx [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03};
  logic [7:0] etx [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05};
  logic [15:0] ftx [6] = '{16'h1, 16'h6, 16'h4, 16'hD, 16'h2, 16'h5};
  logic [15:0] frx [6] = '{16'h1, 16'h6, 16'h4, 16'hD, 16'h1, 16'h3};

  asc_serial i_asc_serial (.ref_clk, .sys_rst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_line,
    .tx_line, .tx_line_oe, .serial_irq);
  asc_line_model i_line (.ref_clk, .tx_wire, .tx_clks, .rx_clks, .send_seq, .send_byte,
    .rx_line, .got_byte, .got_stop, .got_cnt);

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ****************************************
  // Bus access and waits
  // ****************************************
  task automatic acc(input logic w, input logic [2:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    if (avs_waitrequest !== 1'b0)
    begin
      n_errors++;
      conclude();
    end
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wait_st(input int b);
    int n;
    n = 0;
    do
    begin
      acc(1'b0, asc_pkg::IDX_STATUS, 8'h00);
      s = q;
      n++;
    end
    while (s[b] !== 1'b1 && n < 3000);
    if (s[b] !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic wait_got();
    int n;
    n = 0;
    while (got_cnt !== c && n < 20000)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (got_cnt !== c)
    begin
      n_errors++;
      conclude();
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #300000;
    n_errors++;
    conclude();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    tx_clks = 16'h10;
    rx_clks = 16'h10;
    send_seq = 8'h00;
    send_byte = 8'h00;
    n_errors = 0;
    num_checks = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    acc(1'b0, asc_pkg::IDX_STATUS, 8'h00);
    `CHK(q, 8'hC0)
    foreach (z_idx[i])
    begin
      acc(1'b0, z_idx[i], 8'h00);
      `CHK(q, 8'h00)
    end
    foreach (ie_v[i])
    begin
      acc(1'b1, asc_pkg::IDX_CTRL2, ie_v[i]);
      repeat (2) @(posedge ref_clk);
      `CHK(serial_irq, ie_x[i])
    end
    foreach (bd[k])
    begin
      acc(1'b1, asc_pkg::IDX_BAUD, bd[k]);
      acc(1'b1, asc_pkg::IDX_EXT_RX, erx[k]);
      acc(1'b1, asc_pkg::IDX_EXT_TX, etx[k]);
      acc(1'b0, asc_pkg::IDX_BAUD, 8'h00);
      `CHK(q, bd[k])
      tx_clks <= ftx[k] * 16'h10;
      rx_clks <= frx[k] * 16'h10;
      acc(1'b1, asc_pkg::IDX_CTRL2, 8'h2C);
      c = got_cnt + 8'h01;
      acc(1'b0, asc_pkg::IDX_STATUS, 8'h00);
      acc(1'b1, asc_pkg::IDX_DATA, 8'h96 + 8'(k));
      wait_got();
      `CHK(got_byte, 8'h96 + 8'(k))
      `CHK(got_stop, 1'b1)
      send_byte <= 8'h3C ^ 8'(k);
      send_seq <= send_seq + 8'h01;
      wait_st(asc_pkg::SR_RXFULL);
      `CHK(s[asc_pkg::SR_RXFULL], 1'b1)
      `CHK(serial_irq, 1'b1)
      acc(1'b0, asc_pkg::IDX_DATA, 8'h00);
      `CHK(q, 8'h3C ^ 8'(k))
      repeat (2) @(posedge ref_clk);
      `CHK(serial_irq, 1'b0)
    end
    send_byte <= 8'h5A;
    send_seq <= send_seq + 8'h01;
    wait_st(asc_pkg::SR_RXFULL);
    send_byte <= 8'hA5;
    send_seq <= send_seq + 8'h01;
    wait_st(asc_pkg::SR_OVR);
    `CHK(s[asc_pkg::SR_OVR], 1'b1)
    acc(1'b0, asc_pkg::IDX_DATA, 8'h00);
    `CHK(q, 8'h5A)
    acc(1'b1, asc_pkg::IDX_CTRL2, 8'h1C);
    wait_st(asc_pkg::SR_IDLE);
    `CHK(s[asc_pkg::SR_IDLE], 1'b1)
    `CHK(serial_irq, 1'b1)
    c = got_cnt + 8'h01;
    acc(1'b1, asc_pkg::IDX_CTRL2, 8'h09);
    wait_got();
    `CHK(got_byte, 8'h00)
    `CHK(got_stop, 1'b0)
    acc(1'b1, asc_pkg::IDX_CTRL2, 8'h06);
    acc(1'b0, asc_pkg::IDX_CTRL2, 8'h00);
    `CHK(q, 8'h06)
    conclude();
  end
endmodule

bind asc_serial asc_serial_properties i_props (.ref_clk, .sys_rst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_line,
  .tx_line, .tx_line_oe, .serial_irq);

`default_nettype wire

// file: design/asc_pkg.sv
/*
  Constants for the asynchronous serial controller: register indices,
  field positions, reset values, divider codes and state types.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package asc_pkg;

  // ****************************************
  // Register indices (byte address is index times four)
  // ****************************************
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_DATA = 3'h1;
  localparam logic [2:0] IDX_BAUD = 3'h2;
  localparam logic [2:0] IDX_CTRL1 = 3'h3;
  localparam logic [2:0] IDX_CTRL2 = 3'h4;
  localparam logic [2:0] IDX_EXT_RX = 3'h5;
  localparam logic [2:0] IDX_EXT_TX = 3'h7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CR2_TXE_IE = 7;
  localparam int CR2_TXDONE_IE = 6;
  localparam int CR2_RX_IE = 5;
  localparam int CR2_IDLE_IE = 4;
  localparam int CR2_TX_EN = 3;
  localparam int CR2_RX_EN = 2;
  localparam int CR2_MUTE = 1;
  localparam int CR2_BREAK = 0;
  localparam int CR1_R8 = 7;
  localparam int CR1_T8 = 6;
  localparam int CR1_WLEN = 4;
  localparam int CR1_WAKE = 3;
  localparam int SR_TXE = 7;
  localparam int SR_TXDONE = 6;
  localparam int SR_RXFULL = 5;
  localparam int SR_IDLE = 4;
  localparam int SR_OVR = 3;
  localparam int SR_FERR = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CTRL2 = 8'h00;
  localparam logic [6:0] RST_CTRL1 = 7'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [7:0] RST_EXT = 8'h00;
  localparam logic RST_TXE_FLAG = 1'b1;
  localparam logic RST_TXDONE_FLAG = 1'b1;

  // ****************************************
  // Divider and timing constants
  // ****************************************
  localparam logic [10:0] PR_CODE0 = 11'h001;
  localparam logic [10:0] PR_CODE1 = 11'h003;
  localparam logic [10:0] PR_CODE2 = 11'h004;
  localparam logic [10:0] PR_CODE3 = 11'h00D;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;

  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} asc_tx_st_t;
  typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} asc_rx_st_t;

endpackage

// file: design/asc_serial.sv
/*
  Asynchronous serial controller: control registers, data port, baud
  dividers, transmitter, receiver and status flags on an Avalon-MM slave.
  Assumes rx_line comes from a pin and is synchronised here.
*/
// Contract
// - Transmit empty with enable raises interrupt
// - Transmit done with enable raises interrupt
// - Overrun or receive full raise interrupt
// - Idle line with enable raises interrupt
// - Transmit enable; one bit wait first
// - Enable pulse while busy sends preamble
// - Transmit pin released when both disabled
// - Receive enable starts start-bit hunt
// - Mute bit, cleared by hardware on wake
// - Break bit sends breaks; pulse sends one
// - Data port: write transmit, read receive
// - Coarse prescaler codes give 1,3,4,13
// - Transmit divisor is two to code
// - Receive divisor is two to code
// - Nonzero extended receive value divides further
// - Nonzero extended transmit value divides further
// - Extended prescalers reset to zero
// - Transmit empty set on move, sequence clears
// - Overrun keeps held word on full
// - Word length selects eight or nine bits
// - Wake method: idle line or address mark
`timescale 1ns/100ps
`default_nettype none

module asc_serial (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_line,
  output logic tx_line,
  output logic tx_line_oe,
  output logic serial_irq
);

  // ****************************************
  // Divider decoding
  // ****************************************
  function automatic logic [10:0] conv_div(input logic [1:0] pc, input logic [2:0] dc);
    logic [10:0] pr;
    case (pc)
      2'h0: pr = asc_pkg::PR_CODE0;
      2'h1: pr = asc_pkg::PR_CODE1;
      2'h2: pr = asc_pkg::PR_CODE2;
      default: pr = asc_pkg::PR_CODE3;
    endcase
    conv_div = pr << dc;
  endfunction

  function automatic logic [3:0] frame_bits(input logic wlen);
    frame_bits = wlen ? asc_pkg::FRAME_BITS_9 : asc_pkg::FRAME_BITS_8;
  endfunction

  // ****************************************
  // Bus slave and registers
  // ****************************************
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] cr2_r, cr2_nxt;
  logic [6:0] cr1_r, cr1_nxt;
  logic [7:0] baud_r, baud_nxt;
  logic [7:0] ext_rx_r, ext_rx_nxt;
  logic [7:0] ext_tx_r, ext_tx_nxt;
  logic seen_r, seen_nxt;
  logic irq_r, irq_nxt;
  logic [7:0] tx_hold_r, tx_hold_nxt;
  logic acc, acc_rd, acc_wr;
  logic [2:0] idx;
  logic data_wr, data_rd;
  logic wake;
  logic tx_empty_flag_r, tc_r, rx_full_flag_r, or_r, fe_r, idle_r, r8_r;
  logic [7:0] rx_hold_r;
  logic [7:0] status;

  assign idx = avs_address[4:2];
  assign acc = (avs_read | avs_write) & ack_r;
  assign acc_rd = avs_read & ack_r;
  assign acc_wr = avs_write & ack_r & avs_byteenable[0];
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
  assign data_wr = acc_wr & (idx == asc_pkg::IDX_DATA);
  assign data_rd = acc_rd & (idx == asc_pkg::IDX_DATA);
  assign serial_irq = irq_r;

  always_comb
  begin
    status = 8'h00;
    status[asc_pkg::SR_TXE] = tx_empty_flag_r;
    status[asc_pkg::SR_TXDONE] = tc_r;
    status[asc_pkg::SR_RXFULL] = rx_full_flag_r;
    status[asc_pkg::SR_IDLE] = idle_r;
    status[asc_pkg::SR_OVR] = or_r;
    status[asc_pkg::SR_FERR] = fe_r;
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    if (ack_nxt)
    begin
      case (idx)
        asc_pkg::IDX_STATUS: rdata_nxt = {24'h000000, status};
        asc_pkg::IDX_DATA: rdata_nxt = {24'h000000, rx_hold_r};
        asc_pkg::IDX_BAUD: rdata_nxt = {24'h000000, baud_r};
        asc_pkg::IDX_CTRL1: rdata_nxt = {24'h000000, r8_r, cr1_r};
        asc_pkg::IDX_CTRL2: rdata_nxt = {24'h000000, cr2_r};
        asc_pkg::IDX_EXT_RX: rdata_nxt = {24'h000000, ext_rx_r};
        asc_pkg::IDX_EXT_TX: rdata_nxt = {24'h000000, ext_tx_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
    cr2_nxt = cr2_r;
    cr1_nxt = cr1_r;
    baud_nxt = baud_r;
    ext_rx_nxt = ext_rx_r;
    ext_tx_nxt = ext_tx_r;
    tx_hold_nxt = tx_hold_r;
    if (wake)
      cr2_nxt[asc_pkg::CR2_MUTE] = 1'b0;
    if (acc_wr)
    begin
      case (idx)
        asc_pkg::IDX_DATA: tx_hold_nxt = avs_writedata[7:0];
        asc_pkg::IDX_BAUD: baud_nxt = avs_writedata[7:0];
        asc_pkg::IDX_CTRL1: cr1_nxt = avs_writedata[6:0];
        asc_pkg::IDX_CTRL2: cr2_nxt = avs_writedata[7:0];
        asc_pkg::IDX_EXT_RX: ext_rx_nxt = avs_writedata[7:0];
        asc_pkg::IDX_EXT_TX: ext_tx_nxt = avs_writedata[7:0];
        default: cr2_nxt = cr2_nxt;
      endcase
    end
    seen_nxt = seen_r;
    if (data_wr | data_rd)
      seen_nxt = 1'b0;
    if (acc & (idx == asc_pkg::IDX_STATUS))
      seen_nxt = 1'b1;
    irq_nxt = (cr2_r[asc_pkg::CR2_TXE_IE] & tx_empty_flag_r)
      | (cr2_r[asc_pkg::CR2_TXDONE_IE] & tc_r)
      | (cr2_r[asc_pkg::CR2_RX_IE] & (or_r | rx_full_flag_r))
      | (cr2_r[asc_pkg::CR2_IDLE_IE] & idle_r);
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
      cr2_r <= asc_pkg::RST_CTRL2;
      cr1_r <= asc_pkg::RST_CTRL1;
      baud_r <= asc_pkg::RST_BAUD;
      ext_rx_r <= asc_pkg::RST_EXT;
      ext_tx_r <= asc_pkg::RST_EXT;
      tx_hold_r <= 8'h00;
      seen_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      cr2_r <= cr2_nxt;
      cr1_r <= cr1_nxt;
      baud_r <= baud_nxt;
      ext_rx_r <= ext_rx_nxt;
      ext_tx_r <= ext_tx_nxt;
      tx_hold_r <= tx_hold_nxt;
      seen_r <= seen_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ****************************************
  // Baud generators, channel 0 transmit, channel 1 receive
  // ****************************************
  logic [1:0] os_tick;

  for (genvar ch = 0; ch < 2; ch++)
  begin : g_baud
    logic [10:0] conv_cnt_r, conv_cnt_nxt;
    logic [7:0] ext_cnt_r, ext_cnt_nxt;
    logic [10:0] limit;
    logic [7:0] ext;
    logic conv_tick;
    logic tick;
    assign os_tick[ch] = tick;
    always_comb
    begin
      limit = conv_div(baud_r[7:6], (ch == 0) ? baud_r[5:3] : baud_r[2:0]);
      ext = (ch == 0) ? ext_tx_r : ext_rx_r;
      conv_tick = (conv_cnt_r >= limit - 11'h001);
      conv_cnt_nxt = conv_tick ? 11'h000 : conv_cnt_r + 11'h001;
      ext_cnt_nxt = ext_cnt_r;
      if (ext == 8'h00)
      begin
        tick = conv_tick;
        ext_cnt_nxt = 8'h00;
      end
      else
      begin
        tick = conv_tick & (ext_cnt_r >= ext - 8'h01);
        if (conv_tick)
          ext_cnt_nxt = tick ? 8'h00 : ext_cnt_r + 8'h01;
      end
    end
    always_ff @(posedge ref_clk)
    begin
      if (sys_rst)
      begin
        conv_cnt_r <= 11'h000;
        ext_cnt_r <= 8'h00;
      end
      else
      begin
        conv_cnt_r <= conv_cnt_nxt;
        ext_cnt_r <= ext_cnt_nxt;
      end
    end
  end

  // ****************************************
  // Transmitter
  // ****************************************
  asc_pkg::asc_tx_st_t tx_st_r, tx_st_nxt;
  logic [10:0] tx_sh_r, tx_sh_nxt;
  logic [3:0] tx_bits_r, tx_bits_nxt;
  logic [3:0] tx_os_r, tx_os_nxt;
  logic tx_data_r, tx_data_nxt;
  logic te_prev_r, sbk_prev_r, te_ever_r, te_ever_nxt;
  logic wait_pend_r, wait_pend_nxt, pre_pend_r, pre_pend_nxt, brk_pend_r, brk_pend_nxt;
  logic tx_empty_flag_nxt, tc_nxt;
  logic te, send_break_ctl, te_rise, sbk_fall;
  logic tx_pin_r, tx_pin_nxt;

  assign te = cr2_r[asc_pkg::CR2_TX_EN];
  assign send_break_ctl = cr2_r[asc_pkg::CR2_BREAK];
  assign te_rise = te & ~te_prev_r;
  assign sbk_fall = sbk_prev_r & ~send_break_ctl;
  assign tx_line = tx_pin_r;
  assign tx_line_oe = te_ever_r & (te | cr2_r[asc_pkg::CR2_RX_EN]);

  always_comb
  begin
    tx_st_nxt = tx_st_r;
    tx_sh_nxt = tx_sh_r;
    tx_bits_nxt = tx_bits_r;
    tx_os_nxt = tx_os_r;
    tx_data_nxt = tx_data_r;
    te_ever_nxt = te_ever_r | te;
    wait_pend_nxt = wait_pend_r;
    pre_pend_nxt = pre_pend_r;
    brk_pend_nxt = brk_pend_r;
    tx_empty_flag_nxt = tx_empty_flag_r;
    tc_nxt = tc_r;
    if (data_wr & seen_r)
    begin
      tx_empty_flag_nxt = 1'b0;
      tc_nxt = 1'b0;
    end
    if (te_rise)
    begin
      if (tx_st_r == asc_pkg::TX_SHIFT)
        pre_pend_nxt = 1'b1;
      else
        wait_pend_nxt = 1'b1;
    end
    if (sbk_fall & (tx_st_r == asc_pkg::TX_SHIFT))
      brk_pend_nxt = 1'b1;
    case (tx_st_r)
      asc_pkg::TX_IDLE:
      begin
        tx_os_nxt = 4'h0;
        tx_bits_nxt = 4'h0;
        if (te & os_tick[0])
        begin
          tx_st_nxt = asc_pkg::TX_SHIFT;
          tx_data_nxt = 1'b0;
          if (wait_pend_r | te_rise)
          begin
            tx_st_nxt = asc_pkg::TX_WAIT;
            wait_pend_nxt = 1'b0;
          end
          else if (send_break_ctl | brk_pend_r)
          begin
            tx_sh_nxt = 11'h000;
            brk_pend_nxt = 1'b0;
          end
          else if (pre_pend_r)
          begin
            tx_sh_nxt = 11'h7FF;
            pre_pend_nxt = 1'b0;
          end
          else if (~tx_empty_flag_r)
          begin
            tx_sh_nxt = {1'b1, cr1_r[asc_pkg::CR1_WLEN] ? cr1_r[asc_pkg::CR1_T8] : 1'b1,
              tx_hold_r, 1'b0};
            tx_data_nxt = 1'b1;
            tx_empty_flag_nxt = 1'b1;
          end
          else
            tx_st_nxt = asc_pkg::TX_IDLE;
        end
      end
      asc_pkg::TX_WAIT:
      begin
        if (os_tick[0])
        begin
          tx_os_nxt = tx_os_r + 4'h1;
          if (tx_os_r == asc_pkg::OS_LAST)
            tx_st_nxt = asc_pkg::TX_IDLE;
        end
      end
      asc_pkg::TX_SHIFT:
      begin
        if (os_tick[0])
        begin
          tx_os_nxt = tx_os_r + 4'h1;
          if (tx_os_r == asc_pkg::OS_LAST)
          begin
            tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
            tx_bits_nxt = tx_bits_r + 4'h1;
            if (tx_bits_r == frame_bits(cr1_r[asc_pkg::CR1_WLEN]) - 4'h1)
            begin
              tx_st_nxt = asc_pkg::TX_IDLE;
              if (tx_data_r & tx_empty_flag_nxt)
                tc_nxt = 1'b1;
            end
          end
        end
      end
      default: tx_st_nxt = asc_pkg::TX_IDLE;
    endcase
    tx_pin_nxt = (tx_st_nxt == asc_pkg::TX_SHIFT) ? tx_sh_nxt[0] : 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tx_st_r <= asc_pkg::TX_IDLE;
      tx_sh_r <= 11'h7FF;
      tx_bits_r <= 4'h0;
      tx_os_r <= 4'h0;
      tx_data_r <= 1'b0;
      te_prev_r <= 1'b0;
      sbk_prev_r <= 1'b0;
      te_ever_r <= 1'b0;
      wait_pend_r <= 1'b0;
      pre_pend_r <= 1'b0;
      brk_pend_r <= 1'b0;
      tx_empty_flag_r <= asc_pkg::RST_TXE_FLAG;
      tc_r <= asc_pkg::RST_TXDONE_FLAG;
      tx_pin_r <= 1'b1;
    end
    else
    begin
      tx_st_r <= tx_st_nxt;
      tx_sh_r <= tx_sh_nxt;
      tx_bits_r <= tx_bits_nxt;
      tx_os_r <= tx_os_nxt;
      tx_data_r <= tx_data_nxt;
      te_prev_r <= te;
      sbk_prev_r <= send_break_ctl;
      te_ever_r <= te_ever_nxt;
      wait_pend_r <= wait_pend_nxt;
      pre_pend_r <= pre_pend_nxt;
      brk_pend_r <= brk_pend_nxt;
      tx_empty_flag_r <= tx_empty_flag_nxt;
      tc_r <= tc_nxt;
      tx_pin_r <= tx_pin_nxt;
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  asc_pkg::asc_rx_st_t rx_st_r, rx_st_nxt;
  logic rx_s1_r, rx_s2_r;
  logic [3:0] rx_os_r, rx_os_nxt;
  logic [3:0] rx_bit_r, rx_bit_nxt;
  logic [8:0] rx_sh_r, rx_sh_nxt;
  logic [7:0] idle_cnt_r, idle_cnt_nxt;
  logic arm_r, arm_nxt;
  logic rx_full_flag_nxt, or_nxt, fe_nxt, idle_nxt, r8_nxt;
  logic [7:0] rx_hold_nxt;
  logic re, mute, wlen;
  logic [7:0] rx_word;

  assign re = cr2_r[asc_pkg::CR2_RX_EN];
  assign mute = cr2_r[asc_pkg::CR2_MUTE];
  assign wlen = cr1_r[asc_pkg::CR1_WLEN];
  assign rx_word = wlen ? rx_sh_r[7:0] : rx_sh_r[8:1];

  always_comb
  begin
    rx_st_nxt = rx_st_r;
    rx_os_nxt = rx_os_r;
    rx_bit_nxt = rx_bit_r;
    rx_sh_nxt = rx_sh_r;
    idle_cnt_nxt = idle_cnt_r;
    arm_nxt = arm_r;
    rx_full_flag_nxt = rx_full_flag_r;
    or_nxt = or_r;
    fe_nxt = fe_r;
    idle_nxt = idle_r;
    r8_nxt = r8_r;
    rx_hold_nxt = rx_hold_r;
    wake = 1'b0;
    if (data_rd & seen_r)
    begin
      rx_full_flag_nxt = 1'b0;
      or_nxt = 1'b0;
      fe_nxt = 1'b0;
      idle_nxt = 1'b0;
    end
    if (~re)
    begin
      rx_st_nxt = asc_pkg::RX_HUNT;
      idle_cnt_nxt = 8'h00;
    end
    else if (os_tick[1])
    begin
      rx_os_nxt = rx_os_r + 4'h1;
      case (rx_st_r)
        asc_pkg::RX_HUNT:
        begin
          rx_os_nxt = 4'h0;
          if (~rx_s2_r)
          begin
            rx_st_nxt = asc_pkg::RX_START;
            idle_cnt_nxt = 8'h00;
          end
          else if (idle_cnt_r == {frame_bits(wlen), 4'h0})
          begin
            idle_cnt_nxt = 8'h00;
            arm_nxt = 1'b0;
            if (arm_r & mute & ~cr1_r[asc_pkg::CR1_WAKE])
              wake = 1'b1;
            else if (arm_r & ~mute)
              idle_nxt = 1'b1;
          end
          else
            idle_cnt_nxt = idle_cnt_r + 8'h01;
        end
        asc_pkg::RX_START:
        begin
          if (rx_os_r == asc_pkg::OS_MID)
          begin
            rx_os_nxt = 4'h0;
            rx_bit_nxt = 4'h0;
            rx_st_nxt = rx_s2_r ? asc_pkg::RX_HUNT : asc_pkg::RX_BITS;
          end
        end
        asc_pkg::RX_BITS:
        begin
          if (rx_os_r == asc_pkg::OS_LAST)
          begin
            rx_bit_nxt = rx_bit_r + 4'h1;
            if (rx_bit_r != frame_bits(wlen) - 4'h2)
              rx_sh_nxt = {rx_s2_r, rx_sh_r[8:1]};
            else
            begin
              rx_st_nxt = asc_pkg::RX_HUNT;
              arm_nxt = 1'b1;
              if (mute & cr1_r[asc_pkg::CR1_WAKE] & rx_sh_r[8])
                wake = 1'b1;
              if (~mute | wake)
              begin
                if (rx_full_flag_r)
                  or_nxt = 1'b1;
                else
                begin
                  rx_hold_nxt = rx_word;
                  r8_nxt = rx_sh_r[8];
                  fe_nxt = ~rx_s2_r;
                  rx_full_flag_nxt = 1'b1;
                end
              end
            end
          end
        end
        default: rx_st_nxt = asc_pkg::RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rx_st_r <= asc_pkg::RX_HUNT;
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_os_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      idle_cnt_r <= 8'h00;
      arm_r <= 1'b0;
      rx_full_flag_r <= 1'b0;
      or_r <= 1'b0;
      fe_r <= 1'b0;
      idle_r <= 1'b0;
      r8_r <= 1'b0;
      rx_hold_r <= 8'h00;
    end
    else
    begin
      rx_st_r <= rx_st_nxt;
      rx_s1_r <= rx_line;
      rx_s2_r <= rx_s1_r;
      rx_os_r <= rx_os_nxt;
      rx_bit_r <= rx_bit_nxt;
      rx_sh_r <= rx_sh_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      arm_r <= arm_nxt;
      rx_full_flag_r <= rx_full_flag_nxt;
      or_r <= or_nxt;
      fe_r <= fe_nxt;
      idle_r <= idle_nxt;
      r8_r <= r8_nxt;
      rx_hold_r <= rx_hold_nxt;
    end
  end

endmodule

`default_nettype wire
